/* rtl/prei_pkg.sv */
// Purpose: Constants and types shared by the path REI insertion select block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes:   Overhead link timing is counted in overhead clock periods.
package prei_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADR_W         = 14;
  localparam logic [13:0] RX_CTRL_IDX   = 14'h1183;
  localparam logic [13:0] TX_CTRL_IDX   = 14'h0983;
  localparam logic [13:0] G1_VAL_IDX    = 14'h099f;
  localparam logic [13:0] STATUS_IDX    = 14'h0990;
  localparam logic [7:0]  RX_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TX_CTRL_RST   = 8'h00;
  localparam logic [7:0]  G1_VAL_RST    = 8'h00;
  localparam logic [7:0]  RX_CTRL_MASK  = 8'h0f;
  localparam int          STYLE_BIT     = 0;
  localparam int          SRC_LSB       = 5;
  localparam int          SW_REI_LSB    = 4;
  localparam int          ST_AUTO_LSB   = 0;
  localparam int          ST_EXT_LSB    = 4;
  localparam int          ST_TX_LSB     = 8;

  typedef enum logic [1:0] {
    PREI_SRC_AUTO = 2'h0,
    PREI_SRC_SW   = 2'h1,
    PREI_SRC_EXT  = 2'h2
  } prei_src_e;

  // ************************************************************
  // Overhead link timing
  // ************************************************************
  localparam int OVH_CLK_NS    = 125;
  localparam int FRAME_NS      = 125000;
  localparam int FRAME_CLKS    = FRAME_NS / OVH_CLK_NS;
  localparam int WINDOW_CLKS   = 72;
  localparam int REI_WAIT_CLKS = 28;
  localparam int REI_BITS      = 4;
  localparam int FIRST_BIT_CNT = REI_WAIT_CLKS + 1;

  function automatic logic [3:0] prei_count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

endpackage

/* rtl/prei_ovh_if.sv */
// Purpose: Carries the captured external REI nibble out of the link domain.
// Assumes: nibble is stable whenever toggle is seen to change.
// Notes:   toggle flips once per captured nibble.
`timescale 1ns/10ps
`default_nettype none
interface prei_ovh_if;
  logic [3:0] nibble;
  logic       toggle;
  modport src (output nibble, output toggle);
  modport dst (input nibble, input toggle);
endinterface
`default_nettype wire

/* rtl/prei_ovh_port.sv */
// Purpose: Serial overhead input port on the overhead clock.
// Assumes: Partner drives each bit on a falling edge of overhead_serial_clock_i.
// Notes:   Reset is the system reset, resynchronised here.
`timescale 1ns/10ps
`default_nettype none
module prei_ovh_port #(
  parameter int FRAME_CLKS  = prei_pkg::FRAME_CLKS,
  parameter int WINDOW_CLKS = prei_pkg::WINDOW_CLKS
) (
  input  wire logic ovh_clk_i,
  input  wire logic rstn_i,
  input  wire logic serial_in_i,
  output logic      window_o,
  output logic      frame_o,
  prei_ovh_if.src   link
);

  localparam int          CW      = $clog2(FRAME_CLKS);
  localparam logic [CW-1:0] LAST  = CW'(FRAME_CLKS - 1);
  localparam logic [CW-1:0] FIRST = CW'(prei_pkg::FIRST_BIT_CNT);
  localparam logic [CW-1:0] DONE  = CW'(prei_pkg::FIRST_BIT_CNT + prei_pkg::REI_BITS);
  localparam logic [CW-1:0] WIN   = CW'(WINDOW_CLKS);

  logic          rst_meta;
  logic          rstn_l;
  logic [CW-1:0] cnt;
  logic [3:0]    shreg;

  // Reset enters this domain through two flops
  always_ff @(posedge ovh_clk_i)
  begin
    rst_meta <= rstn_i;
    rstn_l   <= rst_meta;
  end

  wire [CW-1:0] next_cnt = (cnt == LAST) ? '0 : cnt + 1'b1;
  wire          in_bits  = (cnt >= FIRST) && (cnt < DONE);

  always_ff @(posedge ovh_clk_i)
  begin
    if (!rstn_l)
    begin
      cnt         <= LAST;
      window_o    <= 1'b0;
      frame_o     <= 1'b0;
      shreg       <= 4'h0;
      link.nibble <= 4'h0;
      link.toggle <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      window_o <= next_cnt < WIN;
      frame_o  <= next_cnt == '0;
      // Partner sees both flags at the edge where cnt leaves zero
      if (in_bits)
        shreg <= {shreg[2:0], serial_in_i};
      if (cnt == DONE)
      begin
        link.nibble <= shreg;
        link.toggle <= ~link.toggle;
      end
    end
  end

  capture_edge_a: assert property (@(posedge ovh_clk_i) disable iff (!rstn_l)
    in_bits |=> shreg[0] == $past(serial_in_i))
    else $error("serial bit not taken at rising edge");

  nibble_time_a: assert property (@(posedge ovh_clk_i) disable iff (!rstn_l)
    (cnt == FIRST) ##4 (cnt == DONE) |=> link.toggle != $past(link.toggle))
    else $error("nibble not handed over after fourth bit");

  frame_in_window_a: assert property (@(posedge ovh_clk_i) disable iff (!rstn_l)
    frame_o |-> window_o ##1 !frame_o)
    else $error("frame flag outside window or too long");

endmodule
`default_nettype wire

/* rtl/prei_top.sv */
// Purpose: Selects the REI-P nibble inserted in each outbound G1 byte.
// Assumes: Classic Wishbone slave; paired receive side on clock_i.
// Notes:   Serial overhead port runs on overhead_serial_clock_i.
// Functional notes
// - Source select 00 takes REI from B3 errors of the paired receiver.
// - Automatic value lands in G1 bits 1 to 4 of every outbound SPE.
// - Style bit 0: value is count of errored B3 bits, 0 to 8.
// - Style bit 1: value is 1 if last SPE had any B3 error.
// - Source select 01 copies G1 value register bits 7:4 into G1 bits 1-4.
// - Source select 10 takes REI bits from the serial overhead input.
// - Each serial bit is sampled on the rising edge after it was driven.
`timescale 1ns/10ps
`default_nettype none
module prei_top #(
  parameter int FRAME_CLKS  = prei_pkg::FRAME_CLKS,
  parameter int WINDOW_CLKS = prei_pkg::WINDOW_CLKS
) (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:2] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_spe_done_i,
  input  wire logic [7:0]  rx_b3_err_i,
  input  wire logic        tx_g1_req_i,
  output logic [3:0]       tx_rei_o,
  output logic             tx_rei_valid_o,
  input  wire logic        overhead_serial_clock_i,
  input  wire logic        overhead_serial_in_i,
  output logic             overhead_window_flag_o,
  output logic             overhead_frame_flag_o
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (FRAME_CLKS <= prei_pkg::FIRST_BIT_CNT + prei_pkg::REI_BITS)
    $error("FRAME_CLKS too small for the REI bit slots");
  if (WINDOW_CLKS < 1 || WINDOW_CLKS >= FRAME_CLKS)
    $error("WINDOW_CLKS must lie inside the frame");

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] rx_ctrl;
  logic [7:0] tx_ctrl;
  logic [7:0] g1_val;
  logic [3:0] auto_rei;
  logic [3:0] ext_rei;
  logic       tog_meta;
  logic       tog_sync;
  logic       tog_seen;

  prei_ovh_if ovh ();

  // ************************************************************
  // Serial overhead port
  // ************************************************************
  prei_ovh_port #(
    .FRAME_CLKS  (FRAME_CLKS),
    .WINDOW_CLKS (WINDOW_CLKS)
  ) u_port (
    .ovh_clk_i   (overhead_serial_clock_i),
    .rstn_i      (rstn_i),
    .serial_in_i (overhead_serial_in_i),
    .window_o    (overhead_window_flag_o),
    .frame_o     (overhead_frame_flag_o),
    .link        (ovh.src)
  );

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
  wire hit_rx   = wb_adr_i == prei_pkg::RX_CTRL_IDX;
  wire hit_tx   = wb_adr_i == prei_pkg::TX_CTRL_IDX;
  wire hit_g1   = wb_adr_i == prei_pkg::G1_VAL_IDX;
  wire hit_st   = wb_adr_i == prei_pkg::STATUS_IDX;

  wire [31:0] status_word = {
    20'h0,
    tx_rei_o,
    ext_rei,
    auto_rei
  };

  // Unmapped addresses answer with zero and drop writes
  wire [31:0] rd_mux =
    hit_rx ? {24'h0, rx_ctrl} :
    hit_tx ? {24'h0, tx_ctrl} :
    hit_g1 ? {24'h0, g1_val}  :
    hit_st ? status_word      : 32'h0;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      rx_ctrl <= prei_pkg::RX_CTRL_RST;
      tx_ctrl <= prei_pkg::TX_CTRL_RST;
      g1_val  <= prei_pkg::G1_VAL_RST;
    end
    else if (wr_lane0)
    begin
      if (hit_rx)
        rx_ctrl <= wb_dat_i[7:0] & prei_pkg::RX_CTRL_MASK;
      if (hit_tx)
        tx_ctrl <= wb_dat_i[7:0];
      if (hit_g1)
        g1_val <= wb_dat_i[7:0];
    end
  end

  // ************************************************************
  // Source selection
  // ************************************************************
  wire       err_style = rx_ctrl[prei_pkg::STYLE_BIT];
  wire [1:0] src_sel   = tx_ctrl[prei_pkg::SRC_LSB +: 2];
  wire [3:0] sw_rei    = g1_val[prei_pkg::SW_REI_LSB +: 4];
  wire [3:0] bit_count = prei_pkg::prei_count_ones(rx_b3_err_i);
  wire       any_err   = |rx_b3_err_i;

  // Count mode reports errored bits, flag mode only whether any
  wire [3:0] next_auto = err_style ? {3'h0, any_err} : bit_count;

  // Code 11 is undefined; it sends the no-error value
  wire [3:0] chosen_rei =
    (src_sel == prei_pkg::PREI_SRC_AUTO) ? auto_rei :
    (src_sel == prei_pkg::PREI_SRC_SW)   ? sw_rei   :
    (src_sel == prei_pkg::PREI_SRC_EXT)  ? ext_rei  : 4'h0;

  // Value held from the latest received SPE until the next one
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      auto_rei <= 4'h0;
    else if (rx_spe_done_i)
      auto_rei <= next_auto;
  end

  // ************************************************************
  // Link crossing
  // ************************************************************
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
    end
    else
    begin
      tog_meta <= ovh.toggle;
      tog_sync <= tog_meta;
    end
  end

  wire ext_new = tog_sync != tog_seen;

  // Nibble is stable for a whole frame after each toggle
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      tog_seen <= 1'b0;
      ext_rei  <= 4'h0;
    end
    else
    begin
      tog_seen <= tog_sync;
      if (ext_new)
        ext_rei <= ovh.nibble;
    end
  end

  // ************************************************************
  // Outbound G1 insertion
  // ************************************************************
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      tx_rei_o       <= 4'h0;
      tx_rei_valid_o <= 1'b0;
    end
    else
    begin
      tx_rei_valid_o <= tx_g1_req_i;
      if (tx_g1_req_i)
        tx_rei_o <= chosen_rei;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  count_style_a: assert property (
    rx_spe_done_i && !err_style
    |=> auto_rei == prei_pkg::prei_count_ones($past(rx_b3_err_i)))
    else $error("auto value is not the errored bit count");

  flag_style_a: assert property (
    rx_spe_done_i && err_style
    |=> auto_rei == {3'h0, |$past(rx_b3_err_i)})
    else $error("auto value is not the any-error flag");

  auto_insert_a: assert property (
    tx_g1_req_i && src_sel == 2'h0 && !rx_spe_done_i
    |=> tx_rei_valid_o && tx_rei_o == auto_rei)
    else $error("auto mode did not insert the computed value");

  every_spe_a: assert property (
    tx_g1_req_i |=> tx_rei_valid_o ##1 !tx_rei_valid_o || $past(tx_g1_req_i))
    else $error("outbound G1 request not answered in one cycle");

  sw_insert_a: assert property (
    tx_g1_req_i && src_sel == 2'h1
    |=> tx_rei_o == $past(g1_val[7:4]))
    else $error("software mode did not copy bits 7:4");

  ext_insert_a: assert property (
    tx_g1_req_i && src_sel == 2'h2 && !ext_new
    |=> tx_rei_o == ext_rei)
    else $error("external mode did not use the serial nibble");

  ext_take_a: assert property (
    ext_new |=> ext_rei == $past(ovh.nibble) ##1 !ext_new)
    else $error("serial nibble not taken after crossing");

  wb_answer_a: assert property (
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");

  reserved_zero_a: assert property (
    wr_lane0 && hit_rx |=> rx_ctrl[7:4] == 4'h0)
    else $error("reserved receive control bits not zero");

  code_undef_a: assert property (
    tx_g1_req_i && src_sel == 2'h3 |=> tx_rei_o == 4'h0)
    else $error("undefined source code did not send zero");

  valid_idle_a: assert property (
    !tx_g1_req_i |=> !tx_rei_valid_o)
    else $error("valid pulse without a G1 request");

  rei_hold_a: assert property (
    !tx_g1_req_i |=> $stable(tx_rei_o))
    else $error("outbound REI changed without a request");

  auto_hold_a: assert property (
    !rx_spe_done_i |=> $stable(auto_rei))
    else $error("auto value changed without a received SPE");

  ext_hold_a: assert property (
    !ext_new |=> $stable(ext_rei))
    else $error("serial value changed without a new nibble");

  idle_data_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");

  g1_read_a: assert property (
    bus_req && !wb_we_i && hit_g1 |=> wb_dat_o == {24'h0, $past(g1_val)})
    else $error("G1 value register read back wrong");

  g1_write_a: assert property (
    wr_lane0 && hit_g1 |=> g1_val == $past(wb_dat_i[7:0]))
    else $error("G1 value register write lost");

  lane_guard_a: assert property (
    bus_req && wb_we_i && !wb_sel_i[0] |=> $stable(tx_ctrl) && $stable(g1_val))
    else $error("write without lane zero changed a register");

endmodule
`default_nettype wire

/* dv/prei_ovh_partner.sv */
// Purpose: Far-end logic feeding REI bits to the serial overhead port.
// Assumes: Flags are sampled on the rising link clock edge.
// Notes:   Outside its four bit slots the line shows the inverse of the last bit.
`timescale 1ns/10ps
`default_nettype none
module prei_ovh_partner (
  input  wire logic       ovh_clk_i,
  input  wire logic       window_i,
  input  wire logic       frame_i,
  input  wire logic [3:0] nibble_i,
  output logic            serial_o
);
  initial
  begin
    serial_o = 1'b0;
    forever
    begin
      @(posedge ovh_clk_i);
      if (window_i && frame_i)
      begin
        repeat (28) @(posedge ovh_clk_i);
        for (int i = 3; i >= 0; i--)
        begin
          @(negedge ovh_clk_i);
          serial_o = nibble_i[i];
        end
        // Hold time over: no stale bit left on the line
        @(negedge ovh_clk_i);
        serial_o = ~serial_o;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/path_rei_insertion_select_tb.sv */
// Purpose: Self-checking bench for the REI source select block.
// Assumes: Small frame of 40 link clocks keeps the run short.
// Notes:   Expected values come from tables, not from the design.
`timescale 1ns/10ps
`default_nettype none
module path_rei_insertion_select_tb;
  logic        clock_i  = 1'b0;
  logic        ovh_clk  = 1'b0;
  logic        rstn_i   = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        wen      = 1'b0;
  logic [13:0] adr      = 14'h0;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        spe_done = 1'b0;
  logic [7:0]  b3_err   = 8'h00;
  logic        g1_req   = 1'b0;
  logic [3:0]  rei;
  logic        rei_vld;
  logic        ser;
  logic        win;
  logic        frm;
  logic [3:0]  nib      = 4'h0;
  int          err_count = 0;
  int          n_tests   = 0;

  localparam int TB_FRAME = 40;
  localparam int TB_WIN   = 8;

  always #5 clock_i = ~clock_i;
  // Link clock free-running, offset in phase from the system clock
  initial
  begin
    #3.3;
    forever #62.5 ovh_clk = ~ovh_clk;
  end

  prei_top #(.FRAME_CLKS(TB_FRAME), .WINDOW_CLKS(TB_WIN)) dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_spe_done_i(spe_done), .rx_b3_err_i(b3_err), .tx_g1_req_i(g1_req),
    .tx_rei_o(rei), .tx_rei_valid_o(rei_vld), .overhead_serial_clock_i(ovh_clk),
    .overhead_serial_in_i(ser), .overhead_window_flag_o(win), .overhead_frame_flag_o(frm)
  );

  prei_ovh_partner far_u (
    .ovh_clk_i(ovh_clk), .window_i(win), .frame_i(frm), .nibble_i(nib), .serial_o(ser)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic cycle; ack sampled on rising edges, release right after the one that sees it
  task automatic wb_xfer(input logic we, input logic [13:0] a, input logic [7:0] d,
                         input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wen  <= we;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h0, d};
    do
    begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd_check(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 8'h00, 4'hf, q);
    check(q, e);
  endtask

  task automatic rx_spe(input logic [7:0] m);
    @(posedge clock_i);
    spe_done <= 1'b1;
    b3_err   <= m;
    @(posedge clock_i);
    spe_done <= 1'b0;
    b3_err   <= ~m;
  endtask

  task automatic tx_check(input logic [3:0] e);
    @(posedge clock_i);
    g1_req <= 1'b1;
    @(posedge clock_i);
    g1_req <= 1'b0;
    @(negedge clock_i);
    check({27'h0, rei_vld, rei}, {27'h0, 1'b1, e});
    @(negedge clock_i);
    check({31'h0, rei_vld}, 32'h0);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    logic [31:0] q;
    rd_check(prei_pkg::TX_CTRL_IDX, 32'h0);
    rd_check(prei_pkg::G1_VAL_IDX, 32'h0);
    rd_check(prei_pkg::RX_CTRL_IDX, 32'h0);
    wr(prei_pkg::RX_CTRL_IDX, 8'hf6);
    rd_check(prei_pkg::RX_CTRL_IDX, 32'h06);
    wb_xfer(1'b1, prei_pkg::TX_CTRL_IDX, 8'h60, 4'h2, q);
    rd_check(prei_pkg::TX_CTRL_IDX, 32'h0);
    wr(14'h0001, 8'hff);
    rd_check(14'h0001, 32'h0);
  endtask

  task automatic t_auto();
    logic [7:0] m[5] = '{8'hff, 8'h07, 8'h00, 8'h80, 8'h5a};
    logic [3:0] c[5] = '{4'h8, 4'h3, 4'h0, 4'h1, 4'h4};
    logic [3:0] f[5] = '{4'h1, 4'h1, 4'h0, 4'h1, 4'h1};
    wr(prei_pkg::TX_CTRL_IDX, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      wr(prei_pkg::RX_CTRL_IDX, s[7:0]);
      for (int i = 0; i < 5; i++)
      begin
        rx_spe(m[i]);
        tx_check(s == 0 ? c[i] : f[i]);
      end
    end
    rd_check(prei_pkg::STATUS_IDX, 32'h101);
  endtask

  // Frame spacing and window length, counted on the link clock
  task automatic t_flags();
    int p;
    int w;
    p = 0;
    w = 0;
    while (frm !== 1'b1 && p < 100)
    begin
      @(negedge ovh_clk);
      p++;
    end
    if (p >= 100)
    begin
      err_count++;
      report_and_stop();
    end
    p = 0;
    do
    begin
      @(negedge ovh_clk);
      p++;
      if (win === 1'b1)
        w++;
    end while (frm !== 1'b1 && p < 100);
    check(p, TB_FRAME);
    check(w, TB_WIN);
  endtask

  task automatic t_sw();
    logic [7:0] g[4] = '{8'h00, 8'h1f, 8'h80, 8'h50};
    wr(prei_pkg::TX_CTRL_IDX, 8'h20);
    for (int i = 0; i < 4; i++)
    begin
      wr(prei_pkg::G1_VAL_IDX, g[i]);
      tx_check(g[i][7:4]);
    end
  endtask

  task automatic t_ext(input logic [3:0] v);
    logic [31:0] q;
    int          n;
    nib <= v;
    n = 0;
    do
    begin
      wb_xfer(1'b0, prei_pkg::STATUS_IDX, 8'h00, 4'hf, q);
      n++;
    end while (q[7:4] !== v && n < 400);
    check({28'h0, q[7:4]}, {28'h0, v});
    if (q[7:4] !== v)
      report_and_stop();
    tx_check(v);
  endtask

  initial
  begin
    repeat (4) @(posedge ovh_clk);
    @(posedge clock_i);
    rstn_i <= 1'b1;
    t_regs();
    t_flags();
    t_auto();
    t_sw();
    wr(prei_pkg::TX_CTRL_IDX, 8'h40);
    t_ext(4'ha);
    t_ext(4'h5);
    wr(prei_pkg::TX_CTRL_IDX, 8'h60);
    tx_check(4'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
